// *** mps_pkg.sv ***
// Purpose: Constants and types for the motor PWM and sampling configuration block.
// Assumes: One clock (ref_clk), synchronous active-high reset.
// Notes: Register indices are byte addresses on an 8-bit plain register port.
package mps_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] PWM_CTRL_ADDR = 2'h0;
  localparam logic [1:0] SAMP_CONF_ADDR = 2'h1;
  localparam logic [7:0] PWM_CTRL_RESET = 8'h00;
  localparam logic [7:0] SAMP_CONF_RESET = 8'h02;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DEBUG_BIT = 7;
  localparam int W_EN_BIT = 6;
  localparam int V_EN_BIT = 5;
  localparam int U_EN_BIT = 4;
  localparam int LATE_FLAG_BIT = 3;
  localparam int LATE_MASK_BIT = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TICK_NS = 2500;
  localparam int PERIPH_CLK_HZ = 4_000_000;
  localparam int CLK_PERIOD_PS = 5000;
  // Peripheral cycles per 2.5 us step; ten at 4 MHz.
  localparam int TICK_CYCLES = (TICK_NS * (PERIPH_CLK_HZ / 1_000_000)) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_WAIT_OFF = 2'b10
  } mps_samp_e;

  typedef struct packed {
    logic commutation;
    logic demag;
    logic crossing;
    logic update;
  } mps_events_s;
endpackage

// *** mps_prescaler.sv ***
// Purpose: Peripheral clock enable generator for the motor controller clock.
// Assumes: ref_clk is the controller clock.
// Notes: Produces a one-cycle enable, not a gated clock, to keep one domain.
`timescale 1ns/1ps
module mps_prescaler
  import mps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] prescaleCode,
  output logic periphTick
);
  typedef struct packed {
    logic [1:0] count;
    logic tick;
  } mps_pre_s;

  mps_pre_s stReg;
  mps_pre_s stNext;

  always_comb begin
    stNext = stReg;
    stNext.count = stReg.count + 2'h1;
    case (prescaleCode)
      2'b00: stNext.tick = 1'b1;
      2'b01: stNext.tick = stReg.count[0];
      default: stNext.tick = (stReg.count == 2'h3);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign periphTick = stReg.tick;
endmodule

// *** mps_top.sv ***
// Purpose: PWM output enables, debug event pins, off time and on-time sample timing.
// Assumes: pwmOn is high in PWM on time; events are one-cycle pulses.
// Notes: Timing counts in peripheral ticks; scale follows the prescaler.
`timescale 1ns/1ps
module mps_top
  import mps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic compare_w_pin_enable,
  input wire logic compare_v_pin_enable,
  input wire logic compare_u_pin_enable,
  input wire logic pwmOn,
  input wire logic speedMode,
  input wire logic sensor_mode_select,
  input wire logic on_time_sampling_enable,
  input wire mps_events_s events,
  input wire logic sampleRequest,
  output logic phase_w_pwm_pin,
  output logic phase_v_pwm_pin,
  output logic phase_u_pwm_pin,
  output logic debug_commutation_pin,
  output logic debug_crossing_pin,
  output logic sampleStrobe,
  output logic offTimeHold,
  output logic lateSampleIrq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] pwmCtrl;
    logic [7:0] sampConf;
    logic [7:0] rdData;
    mps_samp_e sampState;
    logic [7:0] sampCnt;
    logic [7:0] offCnt;
    logic pwmOnDly;
    logic wPin;
    logic vPin;
    logic uPin;
    logic dbgC;
    logic dbgZ;
    logic strobe;
    logic hold;
    logic irq;
  } mps_state_s;

  mps_state_s stReg;
  mps_state_s stNext;
  logic periphTick;

  mps_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .srst(srst),
    .prescaleCode(stReg.sampConf[1:0]),
    .periphTick(periphTick)
  );

  function automatic logic [7:0] ticks(input logic [3:0] code);
    ticks = 8'(code) * 8'(TICK_CYCLES);
  endfunction

  logic [3:0] delayCode;
  logic [3:0] offCode;
  logic lateEvent;
  assign delayCode = stReg.sampConf[7:4];
  assign offCode = stReg.pwmCtrl[3:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    stNext = stReg;
    lateEvent = 1'b0;
    stNext.strobe = 1'b0;
    stNext.pwmOnDly = pwmOn;

    // Register writes.
    if (regWrStb && regAddr == PWM_CTRL_ADDR) begin
      stNext.pwmCtrl = regWrData;
    end
    if (regWrStb && regAddr == SAMP_CONF_ADDR) begin
      stNext.sampConf[7:4] = regWrData[7:4];
      stNext.sampConf[1:0] = regWrData[1:0];
      stNext.sampConf[LATE_MASK_BIT] = regWrData[LATE_MASK_BIT];
      if (!regWrData[LATE_FLAG_BIT]) begin
        stNext.sampConf[LATE_FLAG_BIT] = 1'b0;
      end
    end

    // Output gating.
    stNext.wPin = stReg.pwmCtrl[W_EN_BIT] & compare_w_pin_enable;
    stNext.vPin = stReg.pwmCtrl[V_EN_BIT] & compare_v_pin_enable;
    stNext.uPin = stReg.pwmCtrl[U_EN_BIT] & compare_u_pin_enable;

    // Debug event pins.
    if (stReg.pwmCtrl[DEBUG_BIT]) begin
      if (speedMode) begin
        stNext.dbgC = events.commutation;
        stNext.dbgZ = events.update;
      end else begin
        stNext.dbgC = events.commutation | events.demag;
        stNext.dbgZ = events.crossing;
      end
    end else begin
      stNext.dbgC = 1'b0;
      stNext.dbgZ = 1'b0;
    end

    // Minimum off time, counted from the falling edge of on time.
    if (stReg.pwmOnDly && !pwmOn && !sensor_mode_select && !on_time_sampling_enable
        && delayCode == 4'h0) begin
      stNext.offCnt = ticks(offCode) + 8'(TICK_CYCLES);
    end else if (periphTick && stReg.offCnt != 8'h00) begin
      stNext.offCnt = stReg.offCnt - 8'h01;
    end
    stNext.hold = (stNext.offCnt != 8'h00);

    // Zero-crossing sample timing; demagnetisation sampling never uses this path.
    case (stReg.sampState)
      ST_IDLE: begin
        if (sampleRequest) begin
          if (delayCode == 4'h0) begin
            stNext.sampState = ST_WAIT_OFF;
          end else begin
            stNext.sampCnt = ticks(delayCode);
            stNext.sampState = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        if (stReg.pwmOnDly && !pwmOn) begin
          lateEvent = 1'b1;
          stNext.sampState = ST_IDLE;
        end else if (periphTick) begin
          if (stReg.sampCnt <= 8'h01) begin
            stNext.strobe = 1'b1;
            stNext.sampState = ST_IDLE;
          end else begin
            stNext.sampCnt = stReg.sampCnt - 8'h01;
          end
        end
      end
      ST_WAIT_OFF: begin
        if (!pwmOn) begin
          stNext.strobe = 1'b1;
          stNext.sampState = ST_IDLE;
        end
      end
      default: stNext.sampState = ST_IDLE;
    endcase

    // Set wins over a clearing write in the same cycle.
    if (lateEvent) begin
      stNext.sampConf[LATE_FLAG_BIT] = 1'b1;
    end
    stNext.irq = stNext.sampConf[LATE_FLAG_BIT] & stNext.sampConf[LATE_MASK_BIT];

    // Read data in the cycle after the strobe.
    if (regRdStb) begin
      case (regAddr)
        PWM_CTRL_ADDR: stNext.rdData = stReg.pwmCtrl;
        SAMP_CONF_ADDR: stNext.rdData = stReg.sampConf;
        default: stNext.rdData = 8'h00;
      endcase
    end else begin
      stNext.rdData = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stReg <= '0;
      stReg.pwmCtrl <= PWM_CTRL_RESET;
      stReg.sampConf <= SAMP_CONF_RESET;
      stReg.sampState <= ST_IDLE;
    end else begin
      stReg <= stNext;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData = stReg.rdData;
  assign phase_w_pwm_pin = stReg.wPin;
  assign phase_v_pwm_pin = stReg.vPin;
  assign phase_u_pwm_pin = stReg.uPin;
  assign debug_commutation_pin = stReg.dbgC;
  assign debug_crossing_pin = stReg.dbgZ;
  assign sampleStrobe = stReg.strobe;
  assign offTimeHold = stReg.hold;
  assign lateSampleIrq = stReg.irq;
endmodule

// *** mps_sva.sv ***
// Purpose: Port assertions for mps_top.
// Assumes: One clock; srst synchronous.
// Notes: Register state is not mirrored, so the gates are checked one way only.
`timescale 1ns/1ps
module mps_sva
  import mps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic regWrStb,
  input wire logic compare_w_pin_enable,
  input wire logic compare_v_pin_enable,
  input wire logic compare_u_pin_enable,
  input wire logic speedMode,
  input wire logic sensor_mode_select,
  input wire mps_events_s events,
  input wire logic phase_w_pwm_pin,
  input wire logic phase_v_pwm_pin,
  input wire logic phase_u_pwm_pin,
  input wire logic debug_commutation_pin,
  input wire logic debug_crossing_pin,
  input wire logic sampleStrobe,
  input wire logic offTimeHold,
  input wire logic lateSampleIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_w_gate: assert property (phase_w_pwm_pin |-> $past(compare_w_pin_enable)) else $error("w gate");
  chk_v_gate: assert property (phase_v_pwm_pin |-> $past(compare_v_pin_enable)) else $error("v gate");
  chk_u_gate: assert property (phase_u_pwm_pin |-> $past(compare_u_pin_enable)) else $error("u gate");
  chk_cross_pin: assert property (
    debug_crossing_pin |-> $past(speedMode ? events.update : events.crossing))
    else $error("cross pin");
  chk_comm_pin: assert property (
    debug_commutation_pin |-> $past(events.commutation || (!speedMode && events.demag)))
    else $error("comm pin");
  chk_irq_hold: assert property (
    lateSampleIrq && !regWrStb |=> lateSampleIrq) else $error("irq hold");
  chk_strobe_one: assert property (sampleStrobe |=> !sampleStrobe) else $error("strobe");
  chk_off_sensor: assert property (
    $rose(offTimeHold) |-> $past(!sensor_mode_select)) else $error("off hold");
  cover property (sampleStrobe);
  cover property ($rose(lateSampleIrq));
  cover property ($rose(offTimeHold));
endmodule
bind mps_top mps_sva mps_sva_inst (.ref_clk, .srst, .regWrStb, .compare_w_pin_enable, .compare_v_pin_enable, .compare_u_pin_enable,
  .speedMode, .sensor_mode_select, .events, .phase_w_pwm_pin, .phase_v_pwm_pin,
  .phase_u_pwm_pin, .debug_commutation_pin, .debug_crossing_pin, .sampleStrobe,
  .offTimeHold, .lateSampleIrq);

// *** mps_stage.sv ***
// Purpose: Power stage and debug observer counting high cycles per pin.
// Assumes: Pins are sampled on ref_clk.
// Notes: Counts are 8 bits; scenarios stay far below wrap.
`timescale 1ns/1ps
module mps_stage (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [4:0] pinBus,
  output logic [7:0] pinCount [5]
);
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 5; i++) begin
      pinCount[i] <= srst ? 8'h00 : pinCount[i] + 8'(pinBus[i]);
    end
  end
endmodule

// *** test_motor_pwm_sampling_config.sv ***
// Purpose: Self-checking bench for mps_top.
// Assumes: Prescale 00 gives one peripheral tick a cycle.
// Notes: Sample latency gets a few cycles of slack for tick phase.
`timescale 1ns/1ps
module test_motor_pwm_sampling_config
  import mps_pkg::*;
;
  logic ref_clk = '0, srst = '1, regWrStb = '0, regRdStb = '0, sampleRequest = '0;
  logic compare_w_pin_enable = '0, compare_v_pin_enable = '0, compare_u_pin_enable = '0, pwmOn = '0, speedMode = '0, sensor_mode_select = '0;
  logic on_time_sampling_enable = '0;
  logic [1:0] regAddr = '0;
  logic [7:0] regWrData = '0, regRdData;
  mps_events_s events = '0;
  logic phase_w_pwm_pin, phase_v_pwm_pin, phase_u_pwm_pin, debug_commutation_pin;
  logic debug_crossing_pin, sampleStrobe, offTimeHold, lateSampleIrq;
  logic [7:0] pinCount [5];
  int num_errors = 0, checks = 0, holdCyc = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) holdCyc <= holdCyc + int'(offTimeHold === 1'b1);
  mps_top mps_top_inst (.*);
  mps_stage mps_stage_inst (.ref_clk, .srst, .pinCount, .pinBus({debug_crossing_pin,
    debug_commutation_pin, phase_u_pwm_pin, phase_v_pwm_pin, phase_w_pwm_pin}));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= '1;
    @(posedge ref_clk);
    regWrStb <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    regAddr <= a;
    regRdStb <= '1;
    @(posedge ref_clk);
    regRdStb <= '0;
    #1 chk(regRdData, e);
    @(posedge ref_clk);
  endtask
  task automatic ev(input logic [3:0] v, input int i, input logic [7:0] e);
    events <= v;
    @(posedge ref_clk);
    events <= '0;
    repeat (2) @(posedge ref_clk);
    chk(pinCount[i], e);
  endtask
  task automatic irq(input logic [7:0] e);
    repeat (2) @(posedge ref_clk);
    chk({7'h0, lateSampleIrq}, e);
  endtask
  task automatic samp(output int c);
    sampleRequest <= '1;
    @(posedge ref_clk);
    sampleRequest <= '0;
    c = 0;
    while (sampleStrobe !== 1'b1 && c < 100) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  // The fall is launched beside the request so it lands inside the wait.
  task automatic sampFall(input int k);
    pwmOn <= '1;
    fork
      samp(n);
      begin
        repeat (k) @(posedge ref_clk);
        pwmOn <= '0;
      end
    join
  endtask
  task automatic t_regs();
    rd(2'h1, 8'h02);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'h5A);
    rd(2'h0, 8'h5A);
  endtask
  task automatic t_gate();
    wr(2'h0, 8'h50);
    {compare_w_pin_enable, compare_v_pin_enable, compare_u_pin_enable} <= 3'h7;
    repeat (10) @(posedge ref_clk);
    {compare_w_pin_enable, compare_v_pin_enable, compare_u_pin_enable} <= 3'h0;
    repeat (2) @(posedge ref_clk);
    chk(pinCount[0], 8'h0A);
    chk(pinCount[1], 8'h00);
    chk(pinCount[2], 8'h0A);
  endtask
  task automatic t_dbg();
    wr(2'h0, 8'h80);
    ev(4'h2, 4, 8'h01);
    ev(4'h4, 3, 8'h01);
    ev(4'h8, 3, 8'h02);
    speedMode <= '1;
    ev(4'h1, 4, 8'h02);
    ev(4'h4, 3, 8'h02);
    ev(4'h8, 3, 8'h03);
    speedMode <= '0;
    wr(2'h0, 8'h00);
    ev(4'h2, 4, 8'h02);
  endtask
  task automatic t_samp();
    logic [7:0] cf [4] = '{8'h10, 8'h11, 8'h12, 8'h20};
    int ex [4] = '{10, 20, 40, 20};
    pwmOn <= '1;
    foreach (cf[i]) begin
      wr(2'h1, cf[i]);
      samp(n);
      // The phase of a divided tick can bring the strobe up to one tick early.
      chk(8'(n >= ex[i] - 2 && n <= ex[i] + 1), 8'h01);
    end
    wr(2'h0, 8'h01);
    wr(2'h1, 8'h00);
    sampFall(5);
    chk(8'(n >= 5 && n <= 8), 8'h01);
    repeat (25) @(posedge ref_clk);
    chk(8'(holdCyc), 8'h14);
    rd(2'h1, 8'h00);
    sensor_mode_select <= '1;
    sampFall(5);
    repeat (25) @(posedge ref_clk);
    chk(8'(holdCyc), 8'h14);
    sensor_mode_select <= '0;
    on_time_sampling_enable <= '1;
    sampFall(5);
    repeat (25) @(posedge ref_clk);
    chk(8'(holdCyc), 8'h14);
    on_time_sampling_enable <= '0;
  endtask
  task automatic t_late();
    wr(2'h1, 8'h14);
    sampFall(3);
    chk(8'(n), 8'h64);
    irq(8'h01);
    rd(2'h1, 8'h1C);
    wr(2'h1, 8'h10);
    irq(8'h00);
    sampFall(3);
    irq(8'h00);
    rd(2'h1, 8'h18);
    wr(2'h1, 8'h1C);
    irq(8'h01);
    wr(2'h1, 8'h14);
    irq(8'h00);
    // The clearing write lands on the very edge of the late event.
    fork
      sampFall(3);
      begin
        repeat (3) @(posedge ref_clk);
        wr(2'h1, 8'h14);
      end
    join
    rd(2'h1, 8'h1C);
  endtask
  task automatic t_reset();
    wr(2'h0, 8'hF5);
    srst <= '1;
    repeat (2) @(posedge ref_clk);
    srst <= '0;
    @(posedge ref_clk);
    chk({7'h0, lateSampleIrq}, 8'h00);
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h02);
  endtask
  task automatic summarize();
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= '0;
    @(posedge ref_clk);
    t_regs();
    t_gate();
    t_dbg();
    t_samp();
    t_late();
    t_reset();
    summarize();
  end
endmodule
